/* shared/asp_defs.svh */
// How it works
// - LSB drives a full bit cycle, or half then floats when hold is set.
// - Keeper code: 0 off, 1 on, 2 one LSB cycle, 3 one and a half.
// - Slot 0 MSB moves N bit cycles later, both halves in two-phase formats.
// - Hold, keeper and offset act the same on both data pins.
// - Chain bit 7 clear shares one bus, set forwards upstream data onward.
// - Chain forwarding only takes effect while input mixing is off.
// - Bit 5 low enables bus error detection, high disables it.
// - Bit 4 low resumes after an error clears, high stays down until reconfigured.
// - Format code: 0 TDM, 1 I2S, 2 left-justified, 3 reserved and silent.
// - Word length code: 16, 20, 24, 32 bits; reset picks 32.
`ifndef ASP_DEFS_SVH
`define ASP_DEFS_SVH
`define ASP_OFS_FMT 8'h07
`define ASP_OFS_TIME 8'h08
`define ASP_OFS_CHAIN 8'h09
`define ASP_OFS_MIX 8'h0A
`define ASP_OFS_STAT 8'h0F
`define ASP_RST_FMT 8'h30
`define ASP_RST_TIME 8'h00
`define ASP_RST_CHAIN 8'h00
`define ASP_RST_MIX 8'h00
`define ASP_CHAIN_WMASK 8'hB8
`define ASP_MIX_WMASK 8'hF8
`define ASP_F_FMT 7:6
`define ASP_F_WLEN 5:4
`define ASP_F_HOLD 7
`define ASP_F_KEEP 6:5
`define ASP_F_OFS 4:0
`define ASP_F_DAISY 7
`define ASP_F_ERRDIS 5
`define ASP_F_NORES 4
`define ASP_F_MIX 7:6
`define ASP_WL16 10'h010
`define ASP_WL20 10'h014
`define ASP_WL24 10'h018
`define ASP_WL32 10'h020
`define ASP_FRAME_MAX 10'h200
`define ASP_CNT_SAT 10'h3FF
`define ASP_MCLK_NS 5
`define ASP_STALL_NS 1000
`define ASP_STALL_CYC 8'(`ASP_STALL_NS / `ASP_MCLK_NS)
`define ASP_BUN_W 77
`endif

/* shared/asp_pkg.sv */
package asp_pkg;
  typedef enum logic [1:0] {
    ASP_FMT_TDM = 2'h0,
    ASP_FMT_I2S = 2'h1,
    ASP_FMT_LJ = 2'h2,
    ASP_FMT_RSV = 2'h3
  } asp_fmt_t;
  typedef enum logic [1:0] {
    ASP_KEEP_OFF = 2'h0,
    ASP_KEEP_ON = 2'h1,
    ASP_KEEP_LSB1 = 2'h2,
    ASP_KEEP_LSB15 = 2'h3
  } asp_keep_t;
  typedef enum logic [1:0] {
    ASP_ST_RUN = 2'h0,
    ASP_ST_WAIT = 2'h1,
    ASP_ST_DOWN = 2'h3
  } asp_st_t;
endpackage : asp_pkg

/* rtl/asp_sync.sv */
`timescale 1ns/100ps
module asp_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_q;
  always_ff @(posedge i_clk) begin
    meta_q <= i_async;
    o_sync <= meta_q;
  end
endmodule : asp_sync

/* rtl/asp_errdet.sv */
`timescale 1ns/100ps
`include "asp_defs.svh"
module asp_errdet (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_fs_rise,
  input wire logic [9:0] i_wl,
  output logic o_err
);
  logic [9:0] n_q;
  logic seen_q;
  wire [9:0] flen = n_q + 10'h001;
  wire [9:0] fmin = {i_wl[8:0], 1'b0};
  wire bad = (flen < fmin) || (flen > `ASP_FRAME_MAX);
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      n_q <= 10'h000;
      seen_q <= 1'b0;
      o_err <= 1'b0;
    end else if (i_fs_rise) begin
      n_q <= 10'h000;
      seen_q <= 1'b1;
      o_err <= seen_q & bad;
    end else if (n_q != `ASP_CNT_SAT) begin
      n_q <= n_q + 10'h001;
    end
  end
  a_short_frame: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_fs_rise && seen_q && flen < fmin) |=> o_err)
    else $error("short frame not flagged");
endmodule : asp_errdet

/* rtl/asp_top.sv */
`timescale 1ns/100ps
`include "asp_defs.svh"
module asp_top
  import asp_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_bclk,
  input wire logic i_fsync,
  input wire logic i_sdin,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wen,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [31:0] i_ch1_word,
  input wire logic [31:0] i_ch2_word,
  output logic [7:0] o_reg_rdata,
  output logic o_dout,
  output logic o_dout_oe,
  output logic o_dout2,
  output logic o_dout2_oe,
  output logic o_keeper_en,
  output logic o_tx_active,
  output logic o_bus_err
);
  // Register file, system clock
  logic [7:0] fmt_q, time_q, chain_q, mix_q;
  wire wr_fmt = i_reg_wen && (i_reg_addr == `ASP_OFS_FMT);
  wire wr_time = i_reg_wen && (i_reg_addr == `ASP_OFS_TIME);
  wire wr_chain = i_reg_wen && (i_reg_addr == `ASP_OFS_CHAIN);
  wire wr_mix = i_reg_wen && (i_reg_addr == `ASP_OFS_MIX);
  wire cfg_wr = wr_fmt | wr_time | wr_chain | wr_mix;
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      fmt_q <= `ASP_RST_FMT;
      time_q <= `ASP_RST_TIME;
      chain_q <= `ASP_RST_CHAIN;
      mix_q <= `ASP_RST_MIX;
    end else begin
      if (wr_fmt) fmt_q <= i_reg_wdata;
      if (wr_time) time_q <= i_reg_wdata;
      if (wr_chain) chain_q <= i_reg_wdata & `ASP_CHAIN_WMASK;
      if (wr_mix) mix_q <= i_reg_wdata & `ASP_MIX_WMASK;
    end
  end

  asp_st_t st_q, st_d;
  logic ferr_s, stall_q;
  wire [7:0] stat_w = {5'h00, st_q == ASP_ST_DOWN, stall_q, ferr_s};
  wire [7:0] rd_w = (i_reg_addr == `ASP_OFS_FMT) ? fmt_q :
                    (i_reg_addr == `ASP_OFS_TIME) ? time_q :
                    (i_reg_addr == `ASP_OFS_CHAIN) ? chain_q :
                    (i_reg_addr == `ASP_OFS_MIX) ? mix_q :
                    (i_reg_addr == `ASP_OFS_STAT) ? stat_w : 8'h00;
  always_ff @(posedge i_mclk) begin
    if (i_rst) o_reg_rdata <= 8'h00;
    else o_reg_rdata <= rd_w;
  end

  wire daisy_eff = chain_q[`ASP_F_DAISY] && (mix_q[`ASP_F_MIX] == 2'h0);

  // Word and setting handoff to the bit clock domain
  logic [`ASP_BUN_W-1:0] bun_q;
  logic req_q, ack_s, tog_s, tog_d_q, ack_b_q, tog_b_q, ferr_b;
  wire [`ASP_BUN_W-1:0] bun_d = {i_ch1_word, i_ch2_word, fmt_q[`ASP_F_FMT],
                                 fmt_q[`ASP_F_WLEN], time_q, daisy_eff};
  wire hs_idle = (req_q == ack_s);
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      bun_q <= '0;
      req_q <= 1'b0;
    end else if (hs_idle) begin
      bun_q <= bun_d;
      req_q <= ~req_q;
    end
  end
  asp_sync #(.W(3)) u_sync_m (
    .i_clk(i_mclk),
    .i_async({ferr_b, tog_b_q, ack_b_q}),
    .o_sync({ferr_s, tog_s, ack_s})
  );

  logic [7:0] stall_cnt_q;
  wire bclk_edge = tog_s ^ tog_d_q;
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      tog_d_q <= 1'b0;
      stall_cnt_q <= 8'h00;
      stall_q <= 1'b0;
    end else begin
      tog_d_q <= tog_s;
      stall_cnt_q <= bclk_edge ? 8'h00 :
                     (stall_q ? stall_cnt_q : stall_cnt_q + 8'h01);
      // Stall stays flagged until a bit clock edge returns
      stall_q <= !bclk_edge && (stall_q || (stall_cnt_q == `ASP_STALL_CYC));
    end
  end

  wire err_now = !chain_q[`ASP_F_ERRDIS] && (ferr_s || stall_q);
  wire no_resume = chain_q[`ASP_F_NORES];
  always_comb begin
    st_d = st_q;
    case (st_q)
      ASP_ST_RUN: if (err_now) st_d = no_resume ? ASP_ST_DOWN : ASP_ST_WAIT;
      ASP_ST_WAIT: begin
        if (!err_now) st_d = ASP_ST_RUN;
        else if (no_resume) st_d = ASP_ST_DOWN;
      end
      ASP_ST_DOWN: if (cfg_wr) st_d = ASP_ST_WAIT;
      default: st_d = ASP_ST_DOWN;
    endcase
  end
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      st_q <= ASP_ST_RUN;
      o_tx_active <= 1'b1;
      o_bus_err <= 1'b0;
    end else begin
      st_q <= st_d;
      o_tx_active <= (st_d == ASP_ST_RUN);
      o_bus_err <= err_now;
    end
  end

  // Bit clock domain
  logic brst, req_b, tx_en_b;
  asp_sync #(.W(3)) u_sync_b (
    .i_clk(i_bclk),
    .i_async({i_rst, o_tx_active, req_q}),
    .o_sync({brst, tx_en_b, req_b})
  );
  logic [`ASP_BUN_W-1:0] stage_q, act_q;
  logic fs1_q, fs2_q;
  logic [9:0] cnt_q, hcnt_q;
  logic [63:0] sr_q;
  wire fs_rise = fs1_q & ~fs2_q;
  wire fs_fall = ~fs1_q & fs2_q;
  wire [31:0] wa = act_q[76:45];
  wire [31:0] wb = act_q[44:13];
  asp_fmt_t fmt_a;
  assign fmt_a = asp_fmt_t'(act_q[12:11]);
  wire [1:0] wlen_a = act_q[10:9];
  wire hold_a = act_q[1 + `ASP_F_HOLD];
  asp_keep_t kmode;
  assign kmode = asp_keep_t'(act_q[7:6]);
  wire [4:0] ofs_a = act_q[5:1];
  wire daisy_a = act_q[0];
  wire is_i2s = (fmt_a == ASP_FMT_I2S);
  wire is_tdm = (fmt_a == ASP_FMT_TDM);
  wire fmt_ok = (fmt_a != ASP_FMT_RSV);
  wire start_ev = is_i2s ? fs_fall : fs_rise;
  wire half_ev = is_i2s ? fs_rise : fs_fall;
  wire [9:0] wl = (wlen_a == 2'h0) ? `ASP_WL16 : (wlen_a == 2'h1) ? `ASP_WL20 :
                  (wlen_a == 2'h2) ? `ASP_WL24 : `ASP_WL32;
  wire [9:0] wl_stage = (stage_q[10:9] == 2'h0) ? `ASP_WL16 :
                        (stage_q[10:9] == 2'h1) ? `ASP_WL20 :
                        (stage_q[10:9] == 2'h2) ? `ASP_WL24 : `ASP_WL32;
  wire [9:0] start0 = {9'h000, is_i2s} + {5'h00, ofs_a};
  wire [9:0] start_b = is_tdm ? start0 + wl : start0;
  wire [9:0] pos_b = is_tdm ? cnt_q : hcnt_q;
  wire [9:0] rel_a = cnt_q - start0;
  wire [9:0] rel_b = pos_b - start_b;
  wire in_a = fmt_ok && (cnt_q >= start0) && (rel_a < wl);
  wire in_b = fmt_ok && (pos_b >= start_b) && (rel_b < wl);
  wire [4:0] idx_a = 5'h1F - rel_a[4:0];
  wire [4:0] idx_b = 5'h1F - rel_b[4:0];
  wire [9:0] tap_w = {wl[8:0], 1'b0} - 10'h001;
  // chain data forwarded outside own words
  wire chain_bit = sr_q[tap_w[5:0]];
  wire fwd = daisy_a && fmt_ok && !(in_a || in_b);
  wire lsb_d = tx_en_b && ((in_a && rel_a == wl - 10'h001) ||
                           (in_b && rel_b == wl - 10'h001));
  wire oe_d = tx_en_b && (in_a || in_b || fwd);
  wire dout_d = in_a ? wa[idx_a] : (in_b ? wb[idx_b] : chain_bit);
  wire dout2_d = in_a ? wb[idx_a] : (in_b ? wa[idx_b] : chain_bit);
  wire keep_d = tx_en_b && ((kmode == ASP_KEEP_ON) ||
                (lsb_d && (kmode == ASP_KEEP_LSB1 || kmode == ASP_KEEP_LSB15)));

  always_ff @(posedge i_bclk) begin
    if (brst) begin
      ack_b_q <= 1'b0;
      stage_q <= '0;
      tog_b_q <= 1'b0;
    end else begin
      tog_b_q <= ~tog_b_q;
      if (req_b != ack_b_q) begin
        stage_q <= bun_q;
        ack_b_q <= req_b;
      end
    end
  end
  always_ff @(posedge i_bclk) begin
    if (brst) begin
      act_q <= '0;
      fs1_q <= 1'b0;
      fs2_q <= 1'b0;
      cnt_q <= `ASP_CNT_SAT;
      hcnt_q <= `ASP_CNT_SAT;
      sr_q <= '0;
    end else begin
      fs1_q <= i_fsync;
      fs2_q <= fs1_q;
      sr_q <= {sr_q[62:0], i_sdin};
      if (start_ev) act_q <= stage_q;
      if (start_ev) cnt_q <= 10'h000;
      else if (cnt_q != `ASP_CNT_SAT) cnt_q <= cnt_q + 10'h001;
      if (half_ev) hcnt_q <= 10'h000;
      else if (hcnt_q != `ASP_CNT_SAT) hcnt_q <= hcnt_q + 10'h001;
    end
  end

  logic dout_q, dout2_q, oe_q, lsb_q, keep_q, in_a_q, hiz_n_q, keep_n_q;
  always_ff @(posedge i_bclk) begin
    if (brst) begin
      dout_q <= 1'b0;
      dout2_q <= 1'b0;
      oe_q <= 1'b0;
      lsb_q <= 1'b0;
      keep_q <= 1'b0;
      in_a_q <= 1'b0;
    end else begin
      dout_q <= dout_d;
      dout2_q <= dout2_d;
      oe_q <= oe_d;
      lsb_q <= lsb_d;
      keep_q <= keep_d;
      in_a_q <= in_a && tx_en_b;
    end
  end
  // second half float, extra half cycle
  always_ff @(negedge i_bclk) begin
    if (brst) begin
      hiz_n_q <= 1'b0;
      keep_n_q <= 1'b0;
    end else begin
      hiz_n_q <= lsb_q && hold_a;
      keep_n_q <= lsb_q && (kmode == ASP_KEEP_LSB15);
    end
  end
  // Half-cycle pin timing needs both edges
  assign o_dout = dout_q;
  assign o_dout2 = dout2_q;
  assign o_dout_oe = oe_q && !(hiz_n_q && lsb_q);
  assign o_dout2_oe = oe_q && !(hiz_n_q && lsb_q);
  assign o_keeper_en = keep_q || keep_n_q;

  asp_errdet u_errdet (
    .i_clk(i_bclk),
    .i_rst(brst),
    .i_fs_rise(fs_rise),
    .i_wl(wl_stage),
    .o_err(ferr_b)
  );

  sequence s_lsb_held;
    lsb_q && hold_a;
  endsequence
  sequence s_lsb_full;
    lsb_q && !hold_a;
  endsequence
  a_lsb_full: assert property (
    @(posedge i_bclk) disable iff (brst)
    s_lsb_full |-> o_dout_oe)
    else $error("full-cycle LSB not driven");
  a_lsb_float: assert property (
    @(posedge i_bclk) disable iff (brst)
    s_lsb_held |-> hiz_n_q && !o_dout_oe && !o_dout2_oe)
    else $error("held LSB not floated in second half");
  a_keeper_off: assert property (
    @(posedge i_bclk) disable iff (brst)
    (kmode == ASP_KEEP_OFF && !lsb_q) |-> ##1 !keep_q || kmode != ASP_KEEP_OFF)
    else $error("keeper on while disabled");
  a_keeper_half: assert property (
    @(posedge i_bclk) disable iff (brst)
    (lsb_q && kmode == ASP_KEEP_LSB15) |-> (keep_q && keep_n_q) ##1 !keep_n_q)
    else $error("keeper not held one and a half cycles");
  a_msb_offset: assert property (
    @(posedge i_bclk) disable iff (brst)
    ($rose(in_a_q) && $past(tx_en_b, 2)) |-> (cnt_q == start0 + 10'h001) || !$stable(act_q))
    else $error("slot 0 MSB at wrong bit position");
  a_pins_same: assert property (
    @(posedge i_bclk) disable iff (brst)
    o_dout_oe == o_dout2_oe)
    else $error("data pins differ in drive timing");
  a_mix_blocks: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (hs_idle && mix_q[`ASP_F_MIX] != 2'h0) |=> !bun_q[0])
    else $error("chain forwarding with mixing on");
  a_detect_off: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    chain_q[`ASP_F_ERRDIS] [*2] |-> !o_bus_err)
    else $error("error flagged with detection off");
  a_stay_down: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (st_q == ASP_ST_DOWN && !cfg_wr) |=> st_q == ASP_ST_DOWN ##0 !o_tx_active)
    else $error("left power down without reconfigure");
  a_auto_resume: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (st_q == ASP_ST_WAIT && !err_now && !no_resume) |=> o_tx_active)
    else $error("no auto resume after error cleared");
endmodule : asp_top

/* testbench/asp_host_model.sv */
`timescale 1ns/100ps
module asp_host_model #(
  parameter int HALF_NS = 80
) (
  input wire logic i_run,
  input wire logic [9:0] i_flen,
  input wire logic i_sdin_lvl,
  output logic o_bclk,
  output logic o_fsync,
  output logic o_sdin,
  output logic [9:0] o_pos
);
  assign o_fsync = (o_pos < (i_flen >> 1));
  assign o_sdin = i_sdin_lvl;
  initial begin
    o_bclk = 1'b0;
    o_pos = 10'h000;
    #37.3;
    forever #(HALF_NS) o_bclk = i_run & ~o_bclk;
  end
  always @(negedge o_bclk) begin
    o_pos <= (o_pos + 10'h001 >= i_flen) ? 10'h000 : o_pos + 10'h001;
  end
endmodule : asp_host_model

/* testbench/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] i_reg_addr = 8'h00;
  logic i_reg_wen = 1'b0;
  logic [7:0] i_reg_wdata = 8'h00;
  logic [31:0] i_ch1_word = 32'hC35AF00F;
  logic [31:0] i_ch2_word = 32'h5A3C0FF0;
  logic run = 1'b1;
  logic sd_lvl = 1'b0;
  logic [9:0] flen = 10'h030;
  logic bclk, fsync, sdin;
  logic [9:0] pos;
  logic [7:0] o_reg_rdata;
  logic o_dout, o_dout_oe, o_dout2, o_dout2_oe, o_keeper_en, o_tx_active, o_bus_err;
  logic d1[0:63], d2[0:63], e1b[0:63], e2b[0:63], ka[0:63], kb[0:63];
  int errors = 0;
  int check_count = 0;
  int cyc = 0;
  always #2.5 i_mclk = ~i_mclk;
  asp_host_model u_host (.i_run(run), .i_flen(flen), .i_sdin_lvl(sd_lvl), .o_bclk(bclk),
    .o_fsync(fsync), .o_sdin(sdin), .o_pos(pos));
  asp_top u_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_bclk(bclk), .i_fsync(fsync),
    .i_sdin(sdin), .i_reg_addr(i_reg_addr), .i_reg_wen(i_reg_wen),
    .i_reg_wdata(i_reg_wdata), .i_ch1_word(i_ch1_word), .i_ch2_word(i_ch2_word),
    .o_reg_rdata(o_reg_rdata), .o_dout(o_dout), .o_dout_oe(o_dout_oe), .o_dout2(o_dout2),
    .o_dout2_oe(o_dout2_oe), .o_keeper_en(o_keeper_en), .o_tx_active(o_tx_active),
    .o_bus_err(o_bus_err));
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chkb(input logic got, input logic exp, input string msg);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : chkb
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s %h", $time, msg, got);
    end
  endtask : chk8
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_mclk);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wen = 1'b1;
    @(negedge i_mclk);
    i_reg_wen = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge i_mclk);
    i_reg_addr = a;
    @(negedge i_mclk);
    chk8(o_reg_rdata, exp, "register read");
  endtask : rd
  // Captures one frame plus a few cycles, mid first and second half
  task automatic cap();
    for (int w = 0; w < 9000 && o_tx_active !== 1'b1; w++) @(negedge i_mclk);
    // New settings need a few bit clocks to reach the staging copy
    repeat (10) @(posedge bclk);
    @(posedge bclk iff pos == 10'h000);
    for (int k = 0; k < 52; k++) begin
      if (k > 0) @(posedge bclk);
      #40;
      d1[k] = o_dout;
      d2[k] = o_dout2;
      ka[k] = o_keeper_en;
      @(negedge bclk);
      #40;
      e1b[k] = o_dout_oe;
      e2b[k] = o_dout2_oe;
      kb[k] = o_keeper_en;
    end
  endtask : cap
  task automatic t_regs();
    rd(8'h07, 8'h30);
    rd(8'h08, 8'h00);
    rd(8'h09, 8'h00);
    rd(8'h0A, 8'h00);
    wr(8'h09, 8'hFF);
    rd(8'h09, 8'hB8);
    wr(8'h0A, 8'hFF);
    rd(8'h0A, 8'hF8);
    wr(8'h08, 8'h5A);
    rd(8'h08, 8'h5A);
    wr(8'h30, 8'hFF);
    rd(8'h30, 8'h00);
    wr(8'h09, 8'h00);
    wr(8'h0A, 8'h00);
    wr(8'h07, 8'h80);
  endtask : t_regs
  task automatic t_tdm(input logic [4:0] ofs, input logic hold);
    int b;
    wr(8'h07, 8'h00);
    wr(8'h08, {hold, 2'h0, ofs});
    cap();
    for (int i = 0; i < 32; i++) begin
      b = 2 + ofs + i;
      chkb(d1[b], i < 16 ? i_ch1_word[31-i] : i_ch2_word[47-i], "primary bit");
      chkb(d2[b], i < 16 ? i_ch2_word[31-i] : i_ch1_word[47-i], "secondary bit");
    end
    chkb(e1b[17+ofs], !hold, "primary lsb half");
    chkb(e1b[33+ofs], !hold, "primary last lsb half");
    chkb(e2b[33+ofs], !hold, "secondary lsb half");
  endtask : t_tdm
  task automatic t_keep(input logic [1:0] m);
    logic [7:0] exp;
    exp = (m == 2'h0) ? 8'h00 : (m == 2'h1) ? 8'h1F : (m == 2'h2) ? 8'h0C : 8'h0E;
    wr(8'h07, 8'h80);
    wr(8'h08, {1'b0, m, 5'h00});
    cap();
    chk8({3'h0, ka[5], ka[17], kb[17], ka[18], kb[18]}, exp, "keeper");
  endtask : t_keep
  task automatic t_fmt(input logic [1:0] f);
    logic any;
    any = 1'b0;
    wr(8'h07, {f, 6'h00});
    wr(8'h08, 8'h00);
    cap();
    for (int k = 0; k < 52; k++) any = any | e1b[k];
    chkb(any, f != 2'h3, "format output");
  endtask : t_fmt
  task automatic t_chain(input logic d, input logic [1:0] mix, input logic exp);
    wr(8'h07, 8'h00);
    wr(8'h09, {d, 7'h00});
    wr(8'h0A, {mix, 6'h00});
    sd_lvl = 1'b1;
    cap();
    chkb(d1[40] & e1b[40], exp, "chain forward");
    sd_lvl = 1'b0;
  endtask : t_chain
  task automatic t_err(input logic [7:0] ctrl, input logic stall);
    int n;
    wr(8'h09, ctrl);
    if (stall) run = 1'b0;
    else flen = 10'h014;
    repeat (3000) @(negedge i_mclk);
    chkb(o_bus_err, !ctrl[5], "error flag");
    chkb(o_tx_active, ctrl[5], "tx during fault");
    rd(8'h0F, {5'h00, ctrl[4] & !ctrl[5], stall, !stall});
    run = 1'b1;
    flen = 10'h030;
    for (n = 0; n < 9000 && o_bus_err !== 1'b0; n++) @(negedge i_mclk);
    repeat (3000) @(negedge i_mclk);
    chkb(o_tx_active, !ctrl[4] | ctrl[5], "tx after fault");
    wr(8'h08, 8'h00);
    for (n = 0; n < 9000 && o_tx_active !== 1'b1; n++) @(negedge i_mclk);
    chkb(o_tx_active, 1'b1, "tx after reconfigure");
  endtask : t_err
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      errors++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (16) @(posedge bclk);
    @(negedge i_mclk);
    i_rst = 1'b0;
    t_regs();
    repeat (4000) @(negedge i_mclk);
    t_tdm(5'h00, 1'b0);
    t_tdm(5'h0D, 1'b1);
    for (int m = 0; m < 4; m++) t_keep(m[1:0]);
    for (int f = 0; f < 4; f++) t_fmt(f[1:0]);
    t_chain(1'b1, 2'h1, 1'b0);
    t_chain(1'b0, 2'h0, 1'b0);
    t_chain(1'b1, 2'h0, 1'b1);
    t_err(8'h00, 1'b1);
    t_err(8'h10, 1'b0);
    t_err(8'h30, 1'b1);
    tally_and_finish();
  end
endmodule : tb_top
